/* File: include/irq_ctrl_pkg.sv */
// constants for the four-level interrupt controller
// assumes a core that reads registers over a plain strobe port and fetches vectors
package irq_ctrl_pkg;
   localparam int          NSRC          = 6;
   localparam int          AW            = 4;
   // register addresses
   localparam logic [3:0]  ADDR_ENABLE   = 4'h0;
   localparam logic [3:0]  ADDR_PRIO_LO  = 4'h1;
   localparam logic [3:0]  ADDR_PRIO_HI  = 4'h2;
   localparam logic [3:0]  ADDR_SELECT   = 4'h3;
   localparam logic [3:0]  ADDR_TIMER    = 4'h4;
   localparam logic [3:0]  ADDR_CARD_EN  = 4'h5;
   localparam logic [3:0]  ADDR_STATUS   = 4'h6;
   // enable register fields
   localparam int          EN_GLOBAL     = 7;
   localparam int          EN_SERIAL     = 4;
   localparam int          EN_TIMER1     = 3;
   localparam int          EN_LINE1      = 2;
   localparam int          EN_TIMER0     = 1;
   localparam int          EN_LINE0      = 0;
   localparam logic [7:0]  ENABLE_RST    = 8'h00;
   localparam logic [7:0]  ENABLE_WMASK  = 8'h9f;
   // select register fields
   localparam int          SEL_CARD_POL  = 7;
   localparam int          SEL_PIN_FLAG  = 6;
   localparam int          SEL_CARD_FLAG = 5;
   localparam int          SEL_RX_FLAG   = 4;
   localparam int          SEL_PIN_POL   = 3;
   localparam int          SEL_PIN_EN    = 2;
   localparam int          SEL_CARD_EN   = 1;
   localparam int          SEL_RX_EN     = 0;
   localparam logic [7:0]  SELECT_RST    = 8'h00;
   // timer control fields held here
   localparam int          TC_LINE1_FLAG = 3;
   localparam int          TC_LINE1_TRIG = 2;
   localparam int          TC_LINE0_FLAG = 1;
   localparam int          TC_LINE0_TRIG = 0;
   // source indices, in polling order
   localparam int          SRC_LINE0     = 0;
   localparam int          SRC_TIMER0    = 1;
   localparam int          SRC_LINE1     = 2;
   localparam int          SRC_TIMER1    = 3;
   localparam int          SRC_SERIAL    = 4;
   localparam int          SRC_CARD      = 5;
   localparam logic [15:0] VEC_LINE0     = 16'h0003;
   localparam logic [15:0] VEC_TIMER0    = 16'h000b;
   localparam logic [15:0] VEC_LINE1     = 16'h0013;
   localparam logic [15:0] VEC_TIMER1    = 16'h001b;
   localparam logic [15:0] VEC_SERIAL    = 16'h0023;
   localparam logic [15:0] VEC_CARD      = 16'h0053;
   localparam logic [2:0]  NO_SRC        = 3'h7;
   localparam logic [4:0]  NO_LEVEL      = 5'h10;
endpackage

/* File: hdl/irq_ctrl.sv */
// four-level interrupt controller with a shared line 1 group
// assumes pins are asynchronous; timer, serial and card requests come from clk logic
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl (
   input  wire  logic                         clk,
   input  wire  logic                         nrst,
   input  wire  logic [irq_ctrl_pkg::AW-1:0]  reg_addr,
   input  wire  logic [7:0]                   reg_wdata,
   input  wire  logic                         reg_wr,
   input  wire  logic                         reg_rd,
   output logic       [7:0]                   reg_rdata,
   input  wire  logic                         ext_line0_pin,
   input  wire  logic                         ext_line1_pin,
   input  wire  logic                         uart_rxd_pin,
   input  wire  logic                         card_presence_pin,
   input  wire  logic                         timer0_overflow,
   input  wire  logic                         timer1_overflow,
   input  wire  logic                         uart_rx_done,
   input  wire  logic                         uart_tx_done,
   input  wire  logic                         card_iface_irq,
   output logic                               irq_req,
   output logic       [15:0]                  irq_vector,
   input  wire  logic                         irq_ack,
   input  wire  logic                         irq_return
);
   import irq_ctrl_pkg::*;

   typedef enum logic [1:0] {
      LVL0 = 2'b00,
      LVL1 = 2'b01,
      LVL2 = 2'b10,
      LVL3 = 2'b11
   } level_t;

   ////////////////////////////////////////////////////////////////////////////
   // registers and synchronisers
   logic [7:0]      irq_enable_q;
   logic [7:0]      source_select_q;
   logic [7:0]      priority_low_bits_q;
   logic [7:0]      priority_high_bits_q;
   logic [3:0]      timer_ctrl_q;
   logic            card_iface_enable_q;
   logic [3:0]      sync1_q;
   logic [3:0]      sync2_q;
   logic            line0_prev_q;
   logic            line1_prev_q;
   logic [3:0]      active_q;
   logic [NSRC-1:0] pending;
   logic [NSRC-1:0] enabled;
   logic [2:0]      win_src;
   logic [1:0]      win_lvl;
   logic [15:0]     irq_vector_q;

   function automatic level_t src_level(input logic [2:0] s);
      return level_t'({priority_high_bits_q[s], priority_low_bits_q[s]});
   endfunction

   function automatic logic [15:0] src_vector(input logic [2:0] s);
      unique case (s)
         3'(SRC_LINE0):  return VEC_LINE0;
         3'(SRC_TIMER0): return VEC_TIMER0;
         3'(SRC_LINE1):  return VEC_LINE1;
         3'(SRC_TIMER1): return VEC_TIMER1;
         3'(SRC_SERIAL): return VEC_SERIAL;
         3'(SRC_CARD):   return VEC_CARD;
         default:        return 16'h0000;
      endcase
   endfunction

   wire logic wr_en  = reg_wr && reg_addr == ADDR_ENABLE;
   wire logic wr_sel = reg_wr && reg_addr == ADDR_SELECT;
   wire logic wr_tc  = reg_wr && reg_addr == ADDR_TIMER;
   wire logic taken  = irq_ack && irq_req;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         // idle high, so no false edge or level flag follows reset
         sync1_q <= 4'hf;
         sync2_q <= 4'hf;
      end else begin
         sync1_q <= {card_presence_pin, uart_rxd_pin, ext_line1_pin, ext_line0_pin};
         sync2_q <= sync1_q;
      end
   end

   wire logic line0_s = sync2_q[0];
   wire logic line1_s = sync2_q[1];
   wire logic rxd_s   = sync2_q[2];
   wire logic card_s  = sync2_q[3];

   always_ff @(posedge clk) begin
      if (!nrst) begin
         line0_prev_q <= 1'b1;
         line1_prev_q <= 1'b1;
      end else begin
         line0_prev_q <= line0_s;
         line1_prev_q <= line1_s;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq_enable_q <= ENABLE_RST;
      end else if (wr_en) begin
         irq_enable_q <= reg_wdata & ENABLE_WMASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         priority_low_bits_q  <= 8'h00;
         priority_high_bits_q <= 8'h00;
         card_iface_enable_q  <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == ADDR_PRIO_LO) priority_low_bits_q <= reg_wdata;
         if (reg_wr && reg_addr == ADDR_PRIO_HI) priority_high_bits_q <= reg_wdata;
         if (reg_wr && reg_addr == ADDR_CARD_EN) card_iface_enable_q <= reg_wdata[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // line 0 and line 1 pin flags
   wire logic line0_edge = line0_prev_q && !line0_s;
   wire logic line1_edge = line1_prev_q && !line1_s;
   wire logic line1_pin_level = source_select_q[SEL_PIN_POL] ? line1_s : !line1_s;
   wire logic line1_pin_hit = source_select_q[SEL_PIN_EN] &&
      (timer_ctrl_q[TC_LINE1_TRIG] ? line1_edge : line1_pin_level);
   wire logic line0_hit = timer_ctrl_q[TC_LINE0_TRIG] ? line0_edge : !line0_s;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         timer_ctrl_q <= 4'h0;
      end else begin
         if (wr_tc) begin
            timer_ctrl_q[TC_LINE1_TRIG] <= reg_wdata[TC_LINE1_TRIG];
            timer_ctrl_q[TC_LINE0_TRIG] <= reg_wdata[TC_LINE0_TRIG];
         end
         if (line0_hit)
            timer_ctrl_q[TC_LINE0_FLAG] <= 1'b1;
         else if (taken && win_src == 3'(SRC_LINE0))
            timer_ctrl_q[TC_LINE0_FLAG] <= 1'b0;
         else if (wr_tc)
            timer_ctrl_q[TC_LINE0_FLAG] <= reg_wdata[TC_LINE0_FLAG];
         if (line1_pin_hit)
            timer_ctrl_q[TC_LINE1_FLAG] <= 1'b1;
         else if (taken && win_src == 3'(SRC_LINE1))
            timer_ctrl_q[TC_LINE1_FLAG] <= 1'b0;
         else if (wr_tc)
            timer_ctrl_q[TC_LINE1_FLAG] <= reg_wdata[TC_LINE1_FLAG];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // source select register with hardware-set flags (set wins over clear)
   wire logic card_hit = source_select_q[SEL_CARD_POL] ? card_s : !card_s;
   wire logic rx_hit   = !rxd_s;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         source_select_q <= SELECT_RST;
      end else begin
         if (wr_sel) source_select_q <= reg_wdata;
         if (line1_pin_hit) source_select_q[SEL_PIN_FLAG] <= 1'b1;
         else if (taken && win_src == 3'(SRC_LINE1)) source_select_q[SEL_PIN_FLAG] <= 1'b0;
         if (rx_hit) source_select_q[SEL_RX_FLAG] <= 1'b1;
         if (card_hit) source_select_q[SEL_CARD_FLAG] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // request gathering and arbitration
   wire logic line1_group = (source_select_q[SEL_PIN_FLAG] && source_select_q[SEL_PIN_EN]) ||
      (source_select_q[SEL_RX_FLAG] && source_select_q[SEL_RX_EN]) ||
      (source_select_q[SEL_CARD_FLAG] && source_select_q[SEL_CARD_EN]);

   always_comb begin
      pending = '0;
      pending[SRC_LINE0]  = timer_ctrl_q[TC_LINE0_FLAG];
      pending[SRC_TIMER0] = timer0_overflow;
      pending[SRC_LINE1]  = line1_group;
      pending[SRC_TIMER1] = timer1_overflow;
      pending[SRC_SERIAL] = uart_rx_done || uart_tx_done;
      pending[SRC_CARD]   = card_iface_irq;
      enabled = '0;
      enabled[SRC_LINE0]  = irq_enable_q[EN_LINE0];
      enabled[SRC_TIMER0] = irq_enable_q[EN_TIMER0];
      enabled[SRC_LINE1]  = irq_enable_q[EN_LINE1];
      enabled[SRC_TIMER1] = irq_enable_q[EN_TIMER1];
      enabled[SRC_SERIAL] = irq_enable_q[EN_SERIAL];
      enabled[SRC_CARD]   = card_iface_enable_q;
      if (!irq_enable_q[EN_GLOBAL]) enabled = '0;
   end

   always_comb begin
      win_src = NO_SRC;
      win_lvl = 2'b00;
      for (int i = 0; i < NSRC; i++) begin
         // strictly greater keeps the earlier source on a tie
         if (pending[i] && enabled[i] &&
             (win_src == NO_SRC || src_level(3'(i)) > level_t'(win_lvl))) begin
            win_src = 3'(i);
            win_lvl = src_level(3'(i));
         end
      end
   end

   // a request wins only above every level in service
   logic [4:0] top_active;
   always_comb begin
      top_active = NO_LEVEL;
      for (int l = 0; l < 4; l++)
         if (active_q[l]) top_active = 5'(l);
   end

   assign irq_req = win_src != NO_SRC &&
      (top_active == NO_LEVEL || 5'(win_lvl) > top_active);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         active_q  <= 4'h0;
      end else begin
         if (taken) begin
            active_q[win_lvl] <= 1'b1;
         end else if (irq_return && top_active != NO_LEVEL) begin
            active_q[top_active[1:0]] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) irq_vector_q <= 16'h0000;
      else irq_vector_q <= src_vector(win_src);
   end
   // registered: shows the winner that the core saw requesting one cycle earlier
   assign irq_vector = irq_vector_q;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_ENABLE:  reg_rdata <= irq_enable_q;
            ADDR_PRIO_LO: reg_rdata <= priority_low_bits_q;
            ADDR_PRIO_HI: reg_rdata <= priority_high_bits_q;
            ADDR_SELECT:  reg_rdata <= source_select_q;
            ADDR_TIMER:   reg_rdata <= {4'h0, timer_ctrl_q};
            ADDR_CARD_EN: reg_rdata <= {7'h00, card_iface_enable_q};
            ADDR_STATUS:  reg_rdata <= {4'h0, active_q};
            default:      reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_global_gate;
      @(posedge clk) disable iff (!nrst) !irq_enable_q[EN_GLOBAL] |-> !irq_req;
   endproperty
   a_global_gate: assert property (p_global_gate) else $error("request while global off");

   property p_top_locked;
      @(posedge clk) disable iff (!nrst) active_q[3] |-> !irq_req;
   endproperty
   a_top_locked: assert property (p_top_locked) else $error("level 3 preempted");

   property p_card_sticky;
      @(posedge clk) disable iff (!nrst)
         source_select_q[SEL_CARD_FLAG] && !wr_sel |=> source_select_q[SEL_CARD_FLAG];
   endproperty
   a_card_sticky: assert property (p_card_sticky) else $error("card flag lost");

   property p_rx_set;
      @(posedge clk) disable iff (!nrst) rx_hit |=> source_select_q[SEL_RX_FLAG];
   endproperty
   a_rx_set: assert property (p_rx_set) else $error("rx flag not set");

   // a taken line 1 request clears the pin flag unless the pin fires again
   sequence s_line1_taken;
      taken && win_src == 3'(SRC_LINE1) && !line1_pin_hit;
   endsequence
   property p_pin_clear;
      @(posedge clk) disable iff (!nrst) s_line1_taken |=> !source_select_q[SEL_PIN_FLAG];
   endproperty
   a_pin_clear: assert property (p_pin_clear) else $error("pin flag not cleared");

   property p_take_marks;
      @(posedge clk) disable iff (!nrst) taken |=> active_q[$past(win_lvl)];
   endproperty
   a_take_marks: assert property (p_take_marks) else $error("taken level not active");

   property p_line1_gate;
      @(posedge clk) disable iff (!nrst) !irq_enable_q[EN_LINE1] |-> win_src != 3'(SRC_LINE1);
   endproperty
   a_line1_gate: assert property (p_line1_gate) else $error("line1 won while off");

   property p_reserved_zero;
      @(posedge clk) disable iff (!nrst) (irq_enable_q & ~ENABLE_WMASK) == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   // read data stands only in the cycle after a read strobe
   property p_rdata_idle;
      @(posedge clk) disable iff (!nrst) !reg_rd |=> reg_rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
endmodule // irq_ctrl
`default_nettype wire

/* File: verification/core_model.sv */
// core model: takes pending interrupts and reports the vector fetched
// assumes irq_req is combinational and irq_vector registered one cycle behind it
`timescale 1ns/1ns
`default_nettype none
module core_model (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        irq_req,
   input  wire logic [15:0] irq_vector,
   input  wire logic        accept,
   input  wire logic        ret_cmd,
   output logic             irq_ack,
   output logic             irq_return,
   output logic             taken_stb,
   output logic [15:0]      taken_vec
);
   ////////////////////////////////////////
   // ack stands one cycle; the vector is taken at the edge that samples it
   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq_ack    <= 1'b0;
         irq_return <= 1'b0;
         taken_stb  <= 1'b0;
         taken_vec  <= 16'h0000;
      end else begin
         irq_ack    <= accept && irq_req && !irq_ack && !taken_stb;
         irq_return <= ret_cmd;
         taken_stb  <= irq_ack;
         if (irq_ack) begin
            taken_vec <= irq_vector;
         end
      end
   end
endmodule // core_model
`default_nettype wire

/* File: verification/irq_ctrl_tb.sv */
// self-checking bench for the interrupt controller
// assumes core_model and irq_ctrl_pkg; pin polarity bits give the active level
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl_tb;
   import irq_ctrl_pkg::*;
   logic        clk, nrst, reg_wr, reg_rd, accept, ret_cmd, rd_d, irq_req, irq_ack, irq_return;
   logic        ext_line0_pin, ext_line1_pin, uart_rxd_pin, card_presence_pin, taken_stb;
   logic        timer0_overflow, timer1_overflow, uart_rx_done, uart_tx_done, card_iface_irq;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, d, m;
   logic [15:0] irq_vector, taken_vec;
   logic [7:0]  rq[$];
   logic [15:0] vq[$];
   logic [15:0] vecs[7] = '{VEC_LINE0, VEC_TIMER0, VEC_LINE1, VEC_TIMER1, VEC_SERIAL,
                            VEC_CARD, VEC_SERIAL};
   int          fails = 0, checks_done = 0, seed = 77, s;
   int          ord[3] = '{3, 6, 5};
   irq_ctrl uut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .ext_line0_pin, .ext_line1_pin, .uart_rxd_pin, .card_presence_pin, .timer0_overflow,
      .timer1_overflow, .uart_rx_done, .uart_tx_done, .card_iface_irq, .irq_req,
      .irq_vector, .irq_ack, .irq_return);
   core_model partner (.clk, .nrst, .irq_req, .irq_vector, .accept, .ret_cmd, .irq_ack,
      .irq_return, .taken_stb, .taken_vec);
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic cmp8(input logic [7:0] a, input logic [7:0] e);
      checks_done++;
      if (a !== e) begin
         fails++;
         $display("Error at %0t: read data %h expected %h", $time, a, e);
      end
   endtask
   task automatic cmp16(input logic [15:0] a, input logic [15:0] e);
      checks_done++;
      if (a !== e) begin
         fails++;
         $display("Error at %0t: vector %h expected %h", $time, a, e);
      end
   endtask
   task automatic cmp1(input logic a, input logic e);
      checks_done++;
      if (a !== e) begin
         fails++;
         $display("Error at %0t: request %b expected %b", $time, a, e);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      rq.push_back(e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
   endtask
   task automatic src(input int n, input logic v);
      case (n)
         0: ext_line0_pin <= !v;
         1: timer0_overflow <= v;
         2: uart_rxd_pin <= !v;
         3: timer1_overflow <= v;
         4: uart_tx_done <= v;
         5: card_iface_irq <= v;
         default: uart_rx_done <= v;
      endcase
   endtask
   // the core accepts after a random stall of 0 to 3 cycles
   task automatic take(input logic [15:0] e);
      int i;
      vq.push_back(e);
      idle($random(seed) & 3);
      @(posedge clk);
      accept <= 1'b1;
      for (i = 0; i < 40 && taken_stb !== 1'b1; i++) @(negedge clk);
      if (taken_stb !== 1'b1) begin
         fails++;
         $display("Error at %0t: no vector fetched", $time);
      end
      @(posedge clk);
      accept <= 1'b0;
   endtask
   task automatic ret();
      @(posedge clk);
      ret_cmd <= 1'b1;
      @(posedge clk);
      ret_cmd <= 1'b0;
      idle(2);
   endtask
   task automatic chk_req(input logic e);
      @(negedge clk);
      cmp1(irq_req, e);
   endtask
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (rd_d) begin
         cmp8(reg_rdata, rq.pop_front());
      end
      if (taken_stb) begin
         cmp16(taken_vec, vq.pop_front());
      end
   end
   initial begin
      #(20000 * 4);
      fails++;
      $display("Error at %0t: watchdog expired", $time);
      report_and_stop();
   end
   initial begin
      {nrst, reg_wr, reg_rd, accept, ret_cmd, timer0_overflow, timer1_overflow} = '0;
      {uart_rx_done, uart_tx_done, card_iface_irq, reg_addr, reg_wdata} = '0;
      {ext_line0_pin, ext_line1_pin, uart_rxd_pin, card_presence_pin} = 4'hf;
      idle(12);
      nrst <= 1'b1;
      rd(ADDR_ENABLE, ENABLE_RST);
      rd(ADDR_SELECT, SELECT_RST);
      rd(4'hf, 8'h00);
      for (s = 0; s < 4; s++) begin
         d = $random(seed);
         wr(ADDR_ENABLE, d & ENABLE_WMASK);
         rd(ADDR_ENABLE, d & ENABLE_WMASK);
      end
      $display("test registers done");
      wr(ADDR_SELECT, 8'h01);
      for (s = 0; s < 7; s++) begin
         m = (s == 5) ? 8'h00 : 8'h01 << ((s == 6) ? 4 : s);
         wr(ADDR_CARD_EN, 8'h00);
         wr(ADDR_ENABLE, 8'h9f & ~m);
         src(s, 1'b1);
         idle(4);
         chk_req(1'b0);
         wr(ADDR_CARD_EN, 8'h01);
         wr(ADDR_ENABLE, 8'h1f);
         chk_req(1'b0);
         wr(ADDR_ENABLE, 8'h80 | m);
         if (s == 2) begin
            rd(ADDR_SELECT, 8'h11);
         end
         take(vecs[s]);
         src(s, 1'b0);
         idle(4);
         wr(ADDR_TIMER, 8'h00);
         wr(ADDR_SELECT, 8'h01);
         ret();
      end
      $display("test vectors done");
      wr(ADDR_ENABLE, 8'h9f);
      wr(ADDR_PRIO_LO, 8'h12);
      wr(ADDR_PRIO_HI, 8'h11);
      src(0, 1'b1);
      src(1, 1'b1);
      src(4, 1'b1);
      idle(4);
      take(VEC_SERIAL);
      src(4, 1'b0);
      ret();
      take(VEC_LINE0);
      src(0, 1'b0);
      idle(4);
      wr(ADDR_TIMER, 8'h00);
      ret();
      take(VEC_TIMER0);
      src(1, 1'b0);
      ret();
      wr(ADDR_PRIO_LO, 8'h00);
      wr(ADDR_PRIO_HI, 8'h00);
      src(5, 1'b1);
      src(6, 1'b1);
      src(3, 1'b1);
      idle(4);
      foreach (ord[i]) begin
         take(vecs[ord[i]]);
         src(ord[i], 1'b0);
         ret();
      end
      $display("test priority done");
      wr(ADDR_PRIO_LO, 8'h2b);
      wr(ADDR_PRIO_HI, 8'h31);
      src(1, 1'b1);
      take(VEC_TIMER0);
      src(3, 1'b1);
      idle(4);
      chk_req(1'b0);
      src(4, 1'b1);
      take(VEC_SERIAL);
      src(5, 1'b1);
      take(VEC_CARD);
      src(0, 1'b1);
      idle(4);
      chk_req(1'b0);
      src(5, 1'b0);
      ret();
      take(VEC_LINE0);
      src(0, 1'b0);
      src(4, 1'b0);
      idle(4);
      wr(ADDR_TIMER, 8'h00);
      ret();
      ret();
      chk_req(1'b0);
      src(1, 1'b0);
      ret();
      take(VEC_TIMER1);
      src(3, 1'b0);
      ret();
      $display("test nesting done");
      wr(ADDR_PRIO_LO, 8'h00);
      wr(ADDR_PRIO_HI, 8'h00);
      wr(ADDR_ENABLE, 8'h84);
      wr(ADDR_TIMER, 8'h04);
      wr(ADDR_SELECT, 8'h04);
      ext_line1_pin <= 1'b0;
      idle(4);
      ext_line1_pin <= 1'b1;
      idle(4);
      rd(ADDR_SELECT, 8'h44);
      take(VEC_LINE1);
      rd(ADDR_SELECT, 8'h04);
      ret();
      wr(ADDR_SELECT, 8'h82);
      idle(4);
      rd(ADDR_SELECT, 8'ha2);
      take(VEC_LINE1);
      card_presence_pin <= 1'b0;
      rd(ADDR_SELECT, 8'ha2);
      wr(ADDR_SELECT, 8'h82);
      rd(ADDR_SELECT, 8'h82);
      ret();
      chk_req(1'b0);
      wr(ADDR_TIMER, 8'h00);
      wr(ADDR_SELECT, 8'h0c);
      take(VEC_LINE1);
      ext_line1_pin <= 1'b0;
      idle(4);
      wr(ADDR_SELECT, 8'h0c);
      ret();
      chk_req(1'b0);
      ext_line1_pin <= 1'b1;
      wr(ADDR_SELECT, 8'h08);
      idle(4);
      chk_req(1'b0);
      $display("test line1 group done");
      wr(ADDR_ENABLE, 8'h81);
      wr(ADDR_TIMER, 8'h01);
      ext_line0_pin <= 1'b0;
      idle(4);
      ext_line0_pin <= 1'b1;
      idle(4);
      rd(ADDR_TIMER, 8'h03);
      take(VEC_LINE0);
      rd(ADDR_TIMER, 8'h01);
      rd(ADDR_STATUS, 8'h01);
      ret();
      rd(ADDR_STATUS, 8'h00);
      $display("test line0 edge done");
      report_and_stop();
   end
endmodule // irq_ctrl_tb
`default_nettype wire
